//--- pcm_board.sv
`timescale 1ns/10ps
module pcm_board (
    output logic       primary_clock,   // Primary clock, still outside test frames
    output logic       secondary_clock, // Secondary clock, still outside test frames
    output logic       vpp_high,        // Programming voltage on the test input
    output logic [7:0] data_in          // Dedicated and bidirectional inputs
);
    // The macrocell pins are not connected here; the board neither observes nor drives them.
    initial begin
        primary_clock = 1'b0;
        secondary_clock = 1'b0;
        vpp_high = 1'b0;
        data_in = 8'h00;
    end
    task automatic drive(input logic s, input logic v);
        if (s)
            secondary_clock <= v;
        else
            primary_clock <= v;
    endtask
    // Clocks stay still while the voltage is raised, so the forced state is not stepped.
    task automatic raise_vpp(input logic v);
        vpp_high <= v;
    endtask
    task automatic put(input logic [7:0] d);
        data_in <= d;
    endtask
endmodule

//--- pcm_clock_ctrl.sv
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/10ps
module pcm_clock_ctrl #(
    parameter int DW = 8,
    parameter int CW = 4
) (
    input  wire logic          pclk,            // APB clock, 10 MHz
    input  wire logic          presetn,         // Asynchronous reset, low active
    input  wire logic          psel,            // APB select
    input  wire logic          penable,         // APB enable
    input  wire logic          pwrite,          // APB direction
    input  wire logic [31:0]   paddr,           // APB byte address
    input  wire logic [31:0]   pwdata,          // APB write data
    output logic [31:0]        prdata,          // APB read data
    output logic               pready,          // APB ready
    output logic               pslverr,         // APB error on unmapped address
    input  wire logic          primary_clock,   // Primary clock pin
    input  wire logic          secondary_clock, // Secondary clock pin
    input  wire logic          vpp_high,        // Programming voltage present on test pin
    input  wire logic [DW-1:0] data_in,         // Dedicated and bidirectional inputs
    output logic [DW-1:0]      pin_out,         // Macrocell pin levels
    output logic [DW-1:0]      pin_oe,          // Macrocell pin enables
    output logic               input_latch_gate,// High while input latches are transparent
    output logic               standby,         // Low-power standby state
    output pcm_pkg::pcm_status_t status         // Mode, security and activity summary
);
    import pcm_pkg::*;

    localparam int CWI = (CW > 1) ? $clog2(CW) : 1;
    localparam int SW  = DW + 3;

    function automatic logic hit(input logic [31:0] a, input logic [7:0] ofs);
        hit = (a[31:8] == 24'h000000) && (a[7:0] == ofs);
    endfunction

    logic [SW-1:0]  sync1_r, sync2_r, sync3_r;
    logic [31:0]    cfg_mem_r [CW];
    logic [31:0]    cfg_mem_nxt [CW];
    logic [DW-1:0]  in_latch_r, in_latch_nxt, mc_r, mc_nxt, oe_r, oe_nxt;
    logic [CWI-1:0] cfg_sel_r, cfg_sel_nxt;
    logic [3:0]     idle_r, idle_nxt;
    logic [31:0]    prdata_r, prdata_nxt;
    logic           err_r, err_nxt, gate_r, gate_nxt;

    logic           primary_clock_s, secondary_clock_s, vpp_s, rise1, rise2, step, activity, secured, transparent;
    logic [DW-1:0]  din_s, buried;
    logic [2:0]     mode;
    logic           setup, wr, rd, wr_prog, wr_erase, wr_pre;
    logic [4:0]     prog_bit;
    logic [CWI-1:0] prog_word;

    assign primary_clock_s   = sync2_r[0];
    assign secondary_clock_s   = sync2_r[1];
    assign vpp_s    = sync2_r[2];
    assign din_s    = sync2_r[SW-1:3];
    assign rise1    = primary_clock_s & ~sync3_r[0];
    assign rise2    = secondary_clock_s & ~sync3_r[1];
    assign activity = sync2_r != sync3_r;

    // Mode and security come only from configuration cells.
    assign mode    = cfg_mem_r[MODE_WORD][MODE_LSB +: 3];
    assign secured = ~cfg_mem_r[SEC_WORD][SEC_BIT];
    assign buried  = cfg_mem_r[BURIED_WORD][DW-1:0];

    assign setup     = psel & ~penable;
    assign wr        = psel & penable & pwrite;
    assign rd        = setup & ~pwrite;
    assign wr_prog   = wr & hit(paddr, OFS_PROG) & ~pwdata[PROG_ERASE_BIT];
    assign wr_erase  = wr & hit(paddr, OFS_PROG) & pwdata[PROG_ERASE_BIT];
    assign wr_pre    = wr & hit(paddr, OFS_PRELOAD) & vpp_s;
    assign prog_bit  = pwdata[PROG_BIT_LSB +: 5];
    assign prog_word = pwdata[PROG_WORD_LSB +: CWI];

    // Modes 2 and 3 pass inputs straight through; others gate on primary clock level.
    always_comb begin
        case (mode)
            3'h2, 3'h3:        transparent = 1'b1;
            3'h0, 3'h4, 3'h6:  transparent = ~primary_clock_s;
            default:           transparent = primary_clock_s;
        endcase
    end

    // Pre-load suspends clocked stepping so a forced value is not overwritten.
    assign step = ~vpp_s & (mode[2] ? rise2 : rise1);

    always_comb begin
        for (int i = 0; i < CW; i++) begin
            cfg_mem_nxt[i] = cfg_mem_r[i];
        end
        if (wr_erase) begin
            for (int i = 0; i < CW; i++) begin
                cfg_mem_nxt[i] = CELL_ERASED;
            end
        end else if (wr_prog && (int'(prog_word) < CW)) begin
            cfg_mem_nxt[prog_word][prog_bit] = 1'b0;
        end

        in_latch_nxt = transparent ? din_s : in_latch_r;
        gate_nxt     = transparent;

        if (wr_pre) begin
            mc_nxt = pwdata[DW-1:0];
        end else if (step) begin
            mc_nxt = in_latch_r;
        end else begin
            mc_nxt = mc_r;
        end

        oe_nxt      = (wr && hit(paddr, OFS_CTRL)) ? pwdata[DW-1:0] : oe_r;
        cfg_sel_nxt = (wr && hit(paddr, OFS_CFG_ADDR)) ? pwdata[CWI-1:0] : cfg_sel_r;

        if (activity) begin
            idle_nxt = 4'h0;
        end else if (idle_r < IDLE_CYC) begin
            idle_nxt = idle_r + 4'h1;
        end else begin
            idle_nxt = idle_r;
        end

        // Read data is captured in the setup cycle so it leaves a flip-flop.
        prdata_nxt = prdata_r;
        err_nxt    = err_r;
        if (setup) begin
            prdata_nxt = 32'h00000000;
            err_nxt    = 1'b0;
            if (hit(paddr, OFS_CTRL)) begin
                prdata_nxt[DW-1:0] = oe_r;
            end else if (hit(paddr, OFS_STATUS)) begin
                prdata_nxt[5:0] = status;
            end else if (hit(paddr, OFS_PROG) || hit(paddr, OFS_PRELOAD)) begin
                prdata_nxt = 32'h00000000;
            end else if (hit(paddr, OFS_CFG_ADDR)) begin
                prdata_nxt[CWI-1:0] = cfg_sel_r;
            end else if (hit(paddr, OFS_CFG_DATA)) begin
                prdata_nxt = secured ? 32'h00000000 : cfg_mem_r[cfg_sel_r];
            end else if (hit(paddr, OFS_MC_STATE)) begin
                prdata_nxt[DW-1:0] = mc_r;
            end else begin
                err_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r    <= '0;
            sync2_r    <= '0;
            sync3_r    <= '0;
            for (int i = 0; i < CW; i++) begin
                cfg_mem_r[i] <= CELL_ERASED;
            end
            in_latch_r <= '0;
            mc_r       <= '0;
            oe_r       <= CTRL_RST[DW-1:0];
            cfg_sel_r  <= '0;
            idle_r     <= 4'h0;
            prdata_r   <= 32'h00000000;
            err_r      <= 1'b0;
            gate_r     <= 1'b0;
        end else begin
            sync1_r    <= {data_in, vpp_high, secondary_clock, primary_clock};
            sync2_r    <= sync1_r;
            sync3_r    <= sync2_r;
            cfg_mem_r  <= cfg_mem_nxt;
            in_latch_r <= in_latch_nxt;
            mc_r       <= mc_nxt;
            oe_r       <= oe_nxt;
            cfg_sel_r  <= cfg_sel_nxt;
            idle_r     <= idle_nxt;
            prdata_r   <= prdata_nxt;
            err_r      <= err_nxt;
            gate_r     <= gate_nxt;
        end
    end

    assign prdata           = prdata_r;
    assign pready           = 1'b1;
    assign pslverr          = err_r & psel & penable;
    assign pin_out          = mc_r;
    // A buried macrocell keeps its pin driven; the board must leave it open.
    assign pin_oe           = oe_r | buried;
    assign input_latch_gate = gate_r;
    assign standby          = (idle_r >= IDLE_CYC);
    assign status           = '{standby: standby, vpp: vpp_s, secured: secured, mode: mode};

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_erase_all_ones;
        wr_erase |=> (cfg_mem_r[0] == CELL_ERASED) && (cfg_mem_r[SEC_WORD][SEC_BIT]);
    endproperty
    a_erase_all_ones: assert property (p_erase_all_ones)
        else $error("erase left a cell at zero");

    property p_prog_clears;
        wr_prog && (int'(prog_word) < CW) |=> !cfg_mem_r[$past(prog_word)][$past(prog_bit)];
    endproperty
    a_prog_clears: assert property (p_prog_clears)
        else $error("programmed cell not zero");

    property p_secondary_only;
        mode[2] && !rise2 && !wr_pre |=> $stable(mc_r);
    endproperty
    a_secondary_only: assert property (p_secondary_only)
        else $error("output stepped without secondary edge");

    property p_primary_step;
        !mode[2] && rise1 && !vpp_s && !wr_pre |=> mc_r == $past(in_latch_r);
    endproperty
    a_primary_step: assert property (p_primary_step)
        else $error("primary edge did not step outputs");

    property p_no_latch_mode23;
        (mode == 3'h2 || mode == 3'h3) && $stable(mode) |=> in_latch_r == $past(din_s);
    endproperty
    a_no_latch_mode23: assert property (p_no_latch_mode23)
        else $error("inputs held in unlatched mode");

    property p_hold_polarity;
        (mode == 3'h0 || mode == 3'h4 || mode == 3'h6) && primary_clock_s |=> $stable(in_latch_r);
    endproperty
    a_hold_polarity: assert property (p_hold_polarity)
        else $error("latch open while primary high");

    property p_preload;
        wr_pre |=> mc_r == $past(pwdata[DW-1:0]);
    endproperty
    a_preload: assert property (p_preload)
        else $error("pre-load value not forced");

    property p_secure_read;
        rd && hit(paddr, OFS_CFG_DATA) && secured |=> prdata == 32'h00000000;
    endproperty
    a_secure_read: assert property (p_secure_read)
        else $error("secured contents were readable");

    property p_standby_entry;
        !activity [*2] |-> ##1 standby;
    endproperty
    a_standby_entry: assert property (p_standby_entry)
        else $error("standby not entered when idle");

    property p_standby_exit;
        activity |=> !standby;
    endproperty
    a_standby_exit: assert property (p_standby_exit)
        else $error("standby kept after activity");

    // A control write must never release a pin whose macrocell is buried.
    property p_buried_driven;
        wr && hit(paddr, OFS_CTRL) |=>
            pin_oe == ($past(pwdata[DW-1:0]) | cfg_mem_r[BURIED_WORD][DW-1:0]);
    endproperty
    a_buried_driven: assert property (p_buried_driven)
        else $error("buried macrocell pin undriven");

    property p_mode_static;
        !$past(wr_prog) && !$past(wr_erase) |-> $stable(mode);
    endproperty
    a_mode_static: assert property (p_mode_static)
        else $error("mode changed without programming");

    c_two_clock_step: cover property (mode[2] && step ##1 $changed(mc_r));
    c_preload:        cover property (vpp_s && wr_pre);
    c_secured_read:   cover property (rd && hit(paddr, OFS_CFG_DATA) && secured);
    c_standby:        cover property (standby ##1 !standby);

endmodule

//--- pcm_clock_ctrl_test.sv
`timescale 1ns/10ps
`define CHK(a, b) \
    begin \
        compares++; \
        if ((a) !== (b)) begin \
            num_errors++; \
            $display("ERROR %0t got %h exp %h", $time, (a), (b)); \
        end \
    end
module pcm_clock_ctrl_test;
    import pcm_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h00000000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic        pc;
    logic        sc;
    logic        vpp;
    logic        gate;
    logic        stb;
    int          act_cnt = 0;
    int          act_base = 0;
    logic        hi_gate;
    logic        lo_gate;
    logic [7:0]  din;
    logic [7:0]  pout;
    logic [7:0]  poe;
    logic [7:0]  d;
    logic [7:0]  prev = 8'h00;
    pcm_status_t st;
    int          num_errors = 0;
    int          compares = 0;
    int          cyc = 0;

    pcm_board board (.primary_clock(pc), .secondary_clock(sc), .vpp_high(vpp), .data_in(din));
    pcm_clock_ctrl #(.DW(8), .CW(4)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .primary_clock(pc), .secondary_clock(sc), .vpp_high(vpp), .data_in(din),
        .pin_out(pout), .pin_oe(poe), .input_latch_gate(gate), .standby(stb), .status(st)
    );

    initial begin
        forever #50 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc++;
        if (stb === 1'b0)
            act_cnt <= act_cnt + 1;
        if (cyc == 5000) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {24'h000000, a};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Four cycles per phase leaves room for the two-stage synchroniser and the gate register.
    task automatic pulse(input logic s);
        board.drive(s, 1'b1);
        repeat (4) @(posedge pclk);
        // Only the primary clock moves the latch gate, so a secondary pulse keeps the low value.
        `CHK(gate, s ? lo_gate : hi_gate)
        board.drive(s, 1'b0);
        repeat (4) @(posedge pclk);
        `CHK(gate, lo_gate)
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        `CHK(poe, 8'hff)
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(rd, 32'h00000027)
        apb(1'b1, OFS_CFG_ADDR, 32'h0);
        for (int m = 0; m < 8; m++) begin
            apb(1'b1, OFS_PROG, 32'h80000000);
            for (int b = 0; b < 3; b++)
                if (!m[b])
                    apb(1'b1, OFS_PROG, 32'(b));
            apb(1'b0, OFS_CFG_DATA, 32'h0);
            `CHK(rd, {29'h1fffffff, 3'(m)})
            apb(1'b0, OFS_STATUS, 32'h0);
            `CHK(rd[2:0], 3'(m))
            `CHK(st.mode, 3'(m))
            hi_gate = (m inside {1, 2, 3, 5, 7});
            lo_gate = (m inside {0, 2, 3, 4, 6});
            d = 8'(m * 37 + 17);
            board.put(d);
            act_base = act_cnt;
            pulse(1'b0);
            pulse(1'b0);
            `CHK(act_cnt > act_base, 1'b1)
            apb(1'b0, OFS_MC_STATE, 32'h0);
            `CHK(rd[7:0], (m < 4) ? d : prev)
            pulse(1'b1);
            apb(1'b0, OFS_MC_STATE, 32'h0);
            `CHK(rd[7:0], d)
            `CHK(pout, d)
            prev = d;
        end
        `CHK(stb, 1'b1)
        apb(1'b1, OFS_PROG, 32'h00000008);
        apb(1'b0, OFS_CFG_DATA, 32'h0);
        `CHK(rd, 32'h00000000)
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(rd[3], 1'b1)
        apb(1'b1, OFS_PROG, 32'h80000000);
        apb(1'b0, OFS_CFG_DATA, 32'h0);
        `CHK(rd, 32'hffffffff)
        apb(1'b1, OFS_PROG, 32'h00000103);
        apb(1'b1, OFS_CTRL, 32'h0);
        `CHK(poe, 8'hf7)
        apb(1'b1, OFS_CTRL, 32'h00000008);
        apb(1'b0, OFS_CTRL, 32'h0);
        `CHK(rd, 32'h00000008)
        `CHK(poe, 8'hff)
        apb(1'b1, OFS_PRELOAD, 32'h0000005a);
        apb(1'b0, OFS_MC_STATE, 32'h0);
        `CHK(rd[7:0], d)
        board.raise_vpp(1'b1);
        repeat (4) @(posedge pclk);
        apb(1'b1, OFS_PRELOAD, 32'h0000005a);
        apb(1'b0, OFS_MC_STATE, 32'h0);
        `CHK(rd[7:0], 8'h5a)
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(rd[4], 1'b1)
        board.raise_vpp(1'b0);
        repeat (4) @(posedge pclk);
        pulse(1'b1);
        apb(1'b0, OFS_MC_STATE, 32'h0);
        `CHK(rd[7:0], d)
        apb(1'b0, 8'h1c, 32'h0);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h00000000)
        finish_test();
    end
endmodule

//--- pcm_pkg.sv
// Contract
// - Configuration cells read one when fresh or erased; programming clears one cell to zero.
// - Eight clock modes; modes 0-3 step outputs on primary, 4-7 on secondary clock.
// - Modes 2 and 3 never latch inputs; other modes latch all inputs on one gate.
// - Modes 0,4,6 latches transparent while primary clock low; modes 1,5,7 while high.
// - With programming voltage raised, every flip-flop may be forced, then normal operation resumes.
// - A programmed security bit blocks all readout of configuration contents; the status register still reports the three mode bits.
// - Erasure sets the security bit to one along with every other configuration cell.
// - Device enters standby about 100 ns after last transition, leaves on activity.
// - A buried macrocell with a pin still drives that pin with its state.
package pcm_pkg;

    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_PROG      = 8'h08;
    localparam logic [7:0] OFS_CFG_ADDR  = 8'h0c;
    localparam logic [7:0] OFS_CFG_DATA  = 8'h10;
    localparam logic [7:0] OFS_PRELOAD   = 8'h14;
    localparam logic [7:0] OFS_MC_STATE  = 8'h18;

    localparam int PROG_BIT_LSB   = 0;
    localparam int PROG_WORD_LSB  = 8;
    localparam int PROG_ERASE_BIT = 31;

    localparam int MODE_WORD      = 0;
    localparam int MODE_LSB       = 0;
    localparam int SEC_WORD       = 0;
    localparam int SEC_BIT        = 8;
    localparam int BURIED_WORD    = 1;

    localparam logic [31:0] CELL_ERASED = 32'hffffffff;
    localparam logic [31:0] CTRL_RST    = 32'h00000000;

    localparam int IDLE_NS        = 100;
    localparam int CLK_PERIOD_NS  = 100;
    localparam int IDLE_CYC_I     = (IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] IDLE_CYC = 4'(IDLE_CYC_I < 1 ? 1 : IDLE_CYC_I);

    typedef struct packed {
        logic       standby;
        logic       vpp;
        logic       secured;
        logic [2:0] mode;
    } pcm_status_t;

endpackage
